// [core/sfb_unit.sv]
// Shift, flag, branch condition, alignment and PC-relative unit
`default_nettype none

module sfb_unit
    import sfb_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Operation request
    input wire logic op_valid_i,
    input wire sfb_pkg::sfb_op_req_s op_req_i,
    input wire logic [31:0] pc_i,
    // Operation result
    output logic [31:0] result_o,
    output logic result_wr_o,
    output sfb_pkg::sfb_flags_s flags_o,
    // Flag restore
    input wire logic flags_wr_i,
    input wire sfb_pkg::sfb_flags_s flags_wdata_i,
    // Branch
    input wire logic branch_valid_i,
    input wire sfb_pkg::sfb_branch_req_s branch_req_i,
    output logic branch_taken_o,
    output logic [31:0] branch_target_o,
    // Data access check
    input wire logic acc_valid_i,
    input wire sfb_pkg::sfb_access_s acc_i,
    output logic acc_req_o,
    output logic align_fault_o
);

    import sfb_pkg::*;

    //==========================================================
    // Declarations
    sfb_flags_s flags_q;
    sfb_flags_s flags_d;
    logic [31:0] result_q;
    logic [31:0] result_d;
    logic result_wr_q;
    logic result_wr_d;
    logic branch_taken_q;
    logic [31:0] branch_target_q;
    logic cond_met;
    logic misaligned;
    logic [31:0] pc_rel;
    logic [31:0] addend;
    logic [32:0] sum;
    logic sub_like;
    logic [31:0] sh_res;
    logic sh_carry;
    logic sh_carry_upd;
    sfb_shift_e sh_kind;
    logic [7:0] sh_amt;

    //==========================================================
    // Shifter
    always_comb begin
        case (op_req_i.op)
            SFB_OP_SHL: sh_kind = SFB_SH_SHL;
            SFB_OP_ROTR: sh_kind = SFB_SH_ROTR;
            default: sh_kind = SFB_SH_SHR;
        endcase
    end

    // Only the low byte of a length register counts
    assign sh_amt = op_req_i.amount;

    sfb_shifter u_shifter (
        .src_i(op_req_i.src_a),
        .amount_i(sh_amt),
        .kind_i(sh_kind),
        .res_o(sh_res),
        .carry_o(sh_carry),
        .carry_upd_o(sh_carry_upd)
    );

    //==========================================================
    // Adder
    // Subtract is add of the inverted operand plus one
    assign sub_like = (op_req_i.op == SFB_OP_SUB) ||
                      (op_req_i.op == SFB_OP_CSUB);
    assign addend = sub_like ? ~op_req_i.src_b : op_req_i.src_b;
    assign sum = {1'b0, op_req_i.src_a} + {1'b0, addend} +
                 {32'h0000_0000, sub_like};

    //==========================================================
    // PC-relative address
    // Shared by the address op and the branch target
    assign pc_rel = pc_i + SFB_PC_AHEAD;

    //==========================================================
    // Next result and flags
    always_comb begin
        result_d = result_q;
        result_wr_d = 1'b0;
        flags_d = flags_q;
        if (op_valid_i) begin
            case (op_req_i.op)
                SFB_OP_SHR,
                SFB_OP_SHL,
                SFB_OP_ROTR: begin
                    result_d = sh_res;
                    result_wr_d = 1'b1;
                    if (op_req_i.set_flags) begin
                        flags_d.n = sh_res[31];
                        flags_d.z = (sh_res == 32'h0000_0000);
                        // Zero length keeps carry; V never touched
                        if (sh_carry_upd) begin
                            flags_d.c = sh_carry;
                        end
                    end
                end
                SFB_OP_ADD,
                SFB_OP_SUB: begin
                    result_d = sum[31:0];
                    result_wr_d = 1'b1;
                    if (op_req_i.set_flags) begin
                        flags_d.n = sum[31];
                        flags_d.z = (sum[31:0] == 32'h0000_0000);
                        flags_d.c = sum[32];
                        flags_d.v = (op_req_i.src_a[31] == addend[31]) &&
                                    (sum[31] != op_req_i.src_a[31]);
                    end
                end
                SFB_OP_CSUB,
                SFB_OP_CADD: begin
                    // Flags as for add or subtract, result dropped
                    flags_d.n = sum[31];
                    flags_d.z = (sum[31:0] == 32'h0000_0000);
                    flags_d.c = sum[32];
                    flags_d.v = (op_req_i.src_a[31] == addend[31]) &&
                                (sum[31] != op_req_i.src_a[31]);
                end
                SFB_OP_ADR: begin
                    // Flags stay as they were
                    result_d = pc_rel + op_req_i.src_b;
                    result_wr_d = 1'b1;
                end
                default: begin
                    result_d = result_q;
                    result_wr_d = 1'b0;
                end
            endcase
        end
        // A software restore wins only when no op is valid this cycle
        if (flags_wr_i && !op_valid_i) begin
            flags_d = flags_wdata_i;
        end
    end

    //==========================================================
    // Flag register
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_q <= SFB_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    //==========================================================
    // Result register
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_q <= SFB_RESULT_RST;
            result_wr_q <= 1'b0;
        end else begin
            result_q <= result_d;
            result_wr_q <= result_wr_d;
        end
    end

    assign result_o = result_q;
    assign result_wr_o = result_wr_q;
    assign flags_o = flags_q;

    //==========================================================
    // Condition evaluation
    // Uses stored flags, so any earlier flag setter counts
    always_comb begin
        case (branch_req_i.cond)
            SFB_CC_EQ: cond_met = flags_q.z;
            SFB_CC_NE: cond_met = !flags_q.z;
            SFB_CC_CS: cond_met = flags_q.c;
            SFB_CC_CC: cond_met = !flags_q.c;
            SFB_CC_MI: cond_met = flags_q.n;
            SFB_CC_PL: cond_met = !flags_q.n;
            SFB_CC_VS: cond_met = flags_q.v;
            SFB_CC_VC: cond_met = !flags_q.v;
            SFB_CC_HI: cond_met = flags_q.c && !flags_q.z;
            SFB_CC_LS: cond_met = !flags_q.c || flags_q.z;
            SFB_CC_GE: cond_met = (flags_q.n == flags_q.v);
            SFB_CC_LT: cond_met = (flags_q.n != flags_q.v);
            SFB_CC_GT: cond_met = !flags_q.z &&
                                  (flags_q.n == flags_q.v);
            SFB_CC_LE: cond_met = flags_q.z ||
                                  (flags_q.n != flags_q.v);
            default: cond_met = 1'b1;
        endcase
    end

    //==========================================================
    // Branch decision
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            branch_taken_q <= 1'b0;
            branch_target_q <= SFB_TARGET_RST;
        end else begin
            branch_taken_q <= branch_valid_i && cond_met;
            // Target only moves on a taken branch
            if (branch_valid_i && cond_met) begin
                branch_target_q <= pc_rel + branch_req_i.offset;
            end
        end
    end

    assign branch_taken_o = branch_taken_q;
    assign branch_target_o = branch_target_q;

    //==========================================================
    // Alignment check
    always_comb begin
        case (acc_i.size)
            SFB_SZ_BYTE: misaligned = 1'b0;
            SFB_SZ_HALF: misaligned = acc_i.addr[0];
            SFB_SZ_WORD,
            SFB_SZ_MULTI: misaligned = |acc_i.addr[1:0];
            default: misaligned = 1'b1;
        endcase
    end

    // Combinational so the transfer never starts; no state moves
    assign align_fault_o = acc_valid_i && misaligned;
    assign acc_req_o = acc_valid_i && !misaligned;

endmodule

`default_nettype wire

// [pkg/sfb_pkg.sv]
// Package: types and constants for the shift, flag and branch unit
//==============================================================
// Operation
// - Right shift moves upper bits down, zero fill
// - Flagged right shift: carry gets bit n-1
// - Shift of 32+ gives zero; 33+ clears carry
// - Left shift moves lower bits up, zero fill
// - Flagged left shift carry bit 32-n; #0 keeps
// - Rotate right wraps low bits to top
// - Flagged rotate: carry gets bit n-1
// - Rotate by 32 returns source, carry bit 31
// - Rotate above 32 equals rotate by n-32
// - Word/halfword need natural alignment; bytes always
// - Misaligned access raises alignment fault instead
// - Relative PC is instruction address plus four
// - Flags not updated keep previous value
// - Flagged op sets N Z C from result; V only from add/subtract
// - Carry from add, no-borrow subtract, or shift
// - Overflow when bit 31 sign is wrong
// - Compares set flags, result never written
// - Branch taken only when flags meet condition
// - Fifteen condition codes, always is default
// - Relative address adds offset, flags untouched
// - Zero shift length: value and carry unchanged
//==============================================================
`default_nettype none

package sfb_pkg;

    //==========================================================
    // Widths and constants
    localparam int unsigned SFB_XLEN = 32;
    localparam int unsigned SFB_AMT_W = 8;
    localparam logic [31:0] SFB_PC_AHEAD = 32'h0000_0004;
    localparam logic [31:0] SFB_RESULT_RST = 32'h0000_0000;
    localparam logic [31:0] SFB_TARGET_RST = 32'h0000_0000;
    localparam logic [7:0] SFB_SHIFT_FULL = 8'h20;

    //==========================================================
    // Operations, one-hot
    typedef enum logic [7:0] {
        SFB_OP_SHR = 8'h01,
        SFB_OP_SHL = 8'h02,
        SFB_OP_ROTR = 8'h04,
        SFB_OP_ADD = 8'h08,
        SFB_OP_SUB = 8'h10,
        SFB_OP_CSUB = 8'h20,
        SFB_OP_CADD = 8'h40,
        SFB_OP_ADR = 8'h80
    } sfb_op_e;

    // Shifter kind, one-hot
    typedef enum logic [2:0] {
        SFB_SH_SHR = 3'h1,
        SFB_SH_SHL = 3'h2,
        SFB_SH_ROTR = 3'h4
    } sfb_shift_e;

    //==========================================================
    // Condition codes
    typedef enum logic [3:0] {
        SFB_CC_EQ = 4'h0,
        SFB_CC_NE = 4'h1,
        SFB_CC_CS = 4'h2,
        SFB_CC_CC = 4'h3,
        SFB_CC_MI = 4'h4,
        SFB_CC_PL = 4'h5,
        SFB_CC_VS = 4'h6,
        SFB_CC_VC = 4'h7,
        SFB_CC_HI = 4'h8,
        SFB_CC_LS = 4'h9,
        SFB_CC_GE = 4'hA,
        SFB_CC_LT = 4'hB,
        SFB_CC_GT = 4'hC,
        SFB_CC_LE = 4'hD,
        SFB_CC_AL = 4'hE
    } sfb_cond_e;

    // Access size
    typedef enum logic [1:0] {
        SFB_SZ_BYTE = 2'h0,
        SFB_SZ_HALF = 2'h1,
        SFB_SZ_WORD = 2'h2,
        SFB_SZ_MULTI = 2'h3
    } sfb_size_e;

    //==========================================================
    // Carriers
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } sfb_flags_s;

    localparam sfb_flags_s SFB_FLAGS_RST = '{1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        sfb_op_e op;
        logic set_flags;
        logic [31:0] src_a;
        logic [31:0] src_b;
        logic [7:0] amount;
    } sfb_op_req_s;

    typedef struct packed {
        sfb_cond_e cond;
        logic [31:0] offset;
    } sfb_branch_req_s;

    typedef struct packed {
        sfb_size_e size;
        logic write;
        logic [31:0] addr;
    } sfb_access_s;

endpackage

`default_nettype wire

// [core/sfb_shifter.sv]
// Barrel shifter with carry-out for right, left and rotate
`default_nettype none

module sfb_shifter
    import sfb_pkg::*;
(
    // Operand
    input wire logic [31:0] src_i,
    input wire logic [7:0] amount_i,
    input wire sfb_pkg::sfb_shift_e kind_i,
    // Result
    output logic [31:0] res_o,
    output logic carry_o,
    output logic carry_upd_o
);

    logic [32:0] rsh;
    logic [32:0] lsh;
    logic [63:0] rot;
    logic [4:0] rot_amt;

    //==========================================================
    // Datapaths
    // Extra bit beside the word catches the last bit shifted out
    assign rsh = {src_i, 1'b0} >> amount_i;
    assign lsh = {1'b0, src_i} << amount_i;
    // Only the low five bits matter: n above 32 acts as n-32
    assign rot_amt = amount_i[4:0];
    assign rot = {src_i, src_i} >> rot_amt;

    //==========================================================
    // Select
    always_comb begin
        res_o = src_i;
        carry_o = 1'b0;
        carry_upd_o = (amount_i != 8'h00);
        case (kind_i)
            SFB_SH_SHR: begin
                res_o = rsh[32:1];
                carry_o = rsh[0];
            end
            SFB_SH_SHL: begin
                res_o = lsh[31:0];
                carry_o = lsh[32];
            end
            SFB_SH_ROTR: begin
                // Zero rotate of a nonzero length is the 32 case
                res_o = rot[31:0];
                carry_o = rot[31];
            end
            default: begin
                res_o = src_i;
                carry_upd_o = 1'b0;
            end
        endcase
        if (amount_i == 8'h00) begin
            res_o = src_i;
        end
    end

endmodule

`default_nettype wire

// [tb/sfb_unit_checker.sv]
// Checker: port relations of the shift, flag and branch unit
`default_nettype none

module sfb_unit_checker
    import sfb_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Operation
    input wire logic op_valid_i,
    input wire sfb_pkg::sfb_op_req_s op_req_i,
    input wire logic [31:0] pc_i,
    input wire logic [31:0] result_o,
    input wire logic result_wr_o,
    input wire sfb_pkg::sfb_flags_s flags_o,
    input wire logic flags_wr_i,
    // Branch
    input wire logic branch_valid_i,
    input wire sfb_pkg::sfb_branch_req_s branch_req_i,
    input wire logic branch_taken_o,
    input wire logic [31:0] branch_target_o,
    // Access
    input wire logic acc_valid_i,
    input wire sfb_pkg::sfb_access_s acc_i,
    input wire logic acc_req_o,
    input wire logic align_fault_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // ========
    // Shift request decode
    logic is_sh;
    assign is_sh = op_valid_i &&
        op_req_i.op inside {SFB_OP_SHR, SFB_OP_SHL, SFB_OP_ROTR};

    a_half_odd: assert property (
        acc_valid_i && acc_i.size == SFB_SZ_HALF && acc_i.addr[0]
        |-> align_fault_o && !acc_req_o) else $error("odd half passed");
    a_byte_ok: assert property (
        acc_valid_i && acc_i.size == SFB_SZ_BYTE |-> acc_req_o &&
        !align_fault_o) else $error("byte access faulted");
    a_word_aligned: assert property (
        acc_valid_i && acc_i.size[1] && acc_i.addr[1:0] != 2'h0
        |-> align_fault_o && !acc_req_o) else $error("word misaligned");
    a_compare_no_write: assert property (
        op_valid_i && op_req_i.op inside {SFB_OP_CSUB, SFB_OP_CADD}
        |=> !result_wr_o && $stable(result_o)) else $error("cmp wrote");
    a_adr_sum: assert property (
        op_valid_i && op_req_i.op == SFB_OP_ADR |=> $stable(flags_o) &&
        result_o == $past(pc_i) + SFB_PC_AHEAD + $past(op_req_i.src_b))
        else $error("relative address wrong");
    a_flags_hold: assert property (
        !op_valid_i && !flags_wr_i |=> $stable(flags_o))
        else $error("flags moved while idle");
    a_shift_keep_v: assert property (
        is_sh |=> flags_o.v == $past(flags_o.v))
        else $error("shift changed overflow");
    a_zero_shift: assert property (
        is_sh && op_req_i.amount == 8'h00 |=> result_o ==
        $past(op_req_i.src_a) && $stable(flags_o.c))
        else $error("zero shift altered value");
    a_wide_shift: assert property (
        is_sh && op_req_i.op != SFB_OP_ROTR && op_req_i.amount[7:5] != 0
        |=> result_o == '0 && result_wr_o) else $error("wide shift");
    a_branch_eq: assert property (
        branch_valid_i && branch_req_i.cond == SFB_CC_EQ
        |=> branch_taken_o == $past(flags_o.z)) else $error("eq branch");
    a_branch_idle: assert property (
        !branch_valid_i |=> !branch_taken_o)
        else $error("branch without request");

    c_taken: cover property (branch_taken_o);
    c_fault: cover property (align_fault_o);
    c_shift32: cover property (is_sh && op_req_i.amount == SFB_SHIFT_FULL);
endmodule

bind sfb_unit sfb_unit_checker u_chk (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .op_valid_i(op_valid_i),
    .op_req_i(op_req_i), .pc_i(pc_i), .result_o(result_o),
    .result_wr_o(result_wr_o), .flags_o(flags_o), .flags_wr_i(flags_wr_i),
    .branch_valid_i(branch_valid_i), .branch_req_i(branch_req_i),
    .branch_taken_o(branch_taken_o), .branch_target_o(branch_target_o),
    .acc_valid_i(acc_valid_i), .acc_i(acc_i), .acc_req_o(acc_req_o),
    .align_fault_o(align_fault_o)
);

`default_nettype wire

// [tb/tb_sfb_unit.sv]
// Testbench: self-checking bench for the shift, flag and branch unit
`default_nettype none

`define CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); \
    end \
end

module tb_sfb_unit;
    timeunit 1ns;
    timeprecision 1ns;
    import sfb_pkg::*;
    logic ref_clk_i = 0, arst_n_i = 0, op_valid_i = 0, flags_wr_i = 0;
    logic branch_valid_i = 0, acc_valid_i = 0;
    sfb_op_req_s op_req_i = '0;
    sfb_branch_req_s branch_req_i = '0;
    sfb_access_s acc_i = '0;
    sfb_flags_s flags_wdata_i = '0, flags_o, e_f;
    logic [31:0] pc_i = '0, result_o, branch_target_o, e_res, e_tgt;
    logic result_wr_o, branch_taken_o, acc_req_o, align_fault_o;
    logic [31:0] seed = 32'h0000_001C;
    logic [7:0] amts [7] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'h21, 8'h40, 8'hFF};
    logic [69:0] notes [$];
    logic [69:0] nt;
    int bad_count = 0, tests_run = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    sfb_unit DUT (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .op_valid_i(op_valid_i),
        .op_req_i(op_req_i), .pc_i(pc_i), .result_o(result_o),
        .result_wr_o(result_wr_o), .flags_o(flags_o), .flags_wr_i(flags_wr_i),
        .flags_wdata_i(flags_wdata_i), .branch_valid_i(branch_valid_i),
        .branch_req_i(branch_req_i), .branch_taken_o(branch_taken_o),
        .branch_target_o(branch_target_o), .acc_valid_i(acc_valid_i),
        .acc_i(acc_i), .acc_req_o(acc_req_o), .align_fault_o(align_fault_o)
    );

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic cond_ok(sfb_cond_e cc, sfb_flags_s f);
        case (cc)
            SFB_CC_EQ: return f.z;
            SFB_CC_NE: return !f.z;
            SFB_CC_CS: return f.c;
            SFB_CC_CC: return !f.c;
            SFB_CC_MI: return f.n;
            SFB_CC_PL: return !f.n;
            SFB_CC_VS: return f.v;
            SFB_CC_VC: return !f.v;
            SFB_CC_HI: return f.c && !f.z;
            SFB_CC_LS: return !f.c || f.z;
            SFB_CC_GE: return f.n == f.v;
            SFB_CC_LT: return f.n != f.v;
            SFB_CC_GT: return !f.z && f.n == f.v;
            SFB_CC_LE: return f.z || f.n != f.v;
            default: return 1'b1;
        endcase
    endfunction

    function automatic sfb_op_req_s mk(sfb_op_e op);
        sfb_op_req_s r;
        r = {op, 1'b0, rnd(), rnd(), 8'h00};
        r.set_flags = r.src_a[0];
        r.amount = r.src_b[8] ? r.src_b[7:0] : {2'h0, r.src_b[5:0]};
        // Relative address offsets stay word aligned and within range
        if (op == SFB_OP_ADR) r.src_b = {22'h0, r.src_b[9:2], 2'h0};
        return r;
    endfunction

    // ========
    // One cycle: drive, note the expected state, check access at once
    task automatic cyc(sfb_op_req_s r, logic ov, logic bv,
                       sfb_branch_req_s b, logic [4:0] fw);
        logic [32:0] s;
        logic [31:0] a, y;
        logic ok, tk, wr;
        sfb_flags_s f;
        int n;
        a = r.src_a;
        n = r.amount;
        op_valid_i = ov;
        op_req_i = r;
        branch_valid_i = bv;
        branch_req_i = b;
        {flags_wr_i, flags_wdata_i} = fw;
        y = rnd();
        pc_i = rnd();
        acc_valid_i = y[0] | y[1];
        acc_i = {y[3:2], y[4], rnd()};
        #1;
        ok = acc_i.size == SFB_SZ_BYTE || (acc_i.size == SFB_SZ_HALF ?
            !acc_i.addr[0] : acc_i.addr[1:0] == 2'h0);
        `CHK({acc_req_o, align_fault_o},
            {acc_valid_i & ok, acc_valid_i & !ok})
        tk = bv && cond_ok(b.cond, e_f);
        if (tk) e_tgt = pc_i + SFB_PC_AHEAD + b.offset;
        f = e_f;
        y = e_res;
        s = {1'b0, a} - {1'b0, r.src_b};
        case (r.op)
            SFB_OP_SHR: begin
                y = n >= 32 ? '0 : a >> n;
                if (n != 0) f.c = n > 32 ? 1'b0 : a[n - 1];
            end
            SFB_OP_SHL: begin
                y = n >= 32 ? '0 : a << n;
                if (n != 0) f.c = n > 32 ? 1'b0 : a[32 - n];
            end
            SFB_OP_ROTR: begin
                y = (a >> (n % 32)) | (a << (32 - n % 32));
                if (n != 0) f.c = a[(n + 31) % 32];
            end
            SFB_OP_ADD, SFB_OP_CADD: begin
                s = {1'b0, a} + {1'b0, r.src_b};
                y = s[31:0];
                f.c = s[32];
                f.v = a[31] == r.src_b[31] && s[31] != a[31];
            end
            SFB_OP_SUB, SFB_OP_CSUB: begin
                y = s[31:0];
                f.c = !s[32];
                f.v = a[31] != r.src_b[31] && s[31] != a[31];
            end
            default: y = pc_i + SFB_PC_AHEAD + r.src_b;
        endcase
        f.n = y[31];
        f.z = y == '0;
        wr = ov && !(r.op inside {SFB_OP_CSUB, SFB_OP_CADD});
        if (ov && r.op != SFB_OP_ADR && (r.set_flags || !wr)) e_f = f;
        else if (!ov && fw[4]) e_f = fw[3:0];
        if (wr) e_res = y;
        @(posedge ref_clk_i);
        notes.push_back({e_res, wr, e_f, tk, e_tgt});
        #1;
    endtask

    // Idle first so the last note is compared before outputs clear
    task automatic do_reset();
        op_valid_i = 0;
        branch_valid_i = 0;
        flags_wr_i = 0;
        @(posedge ref_clk_i);
        #1;
        arst_n_i = 0;
        e_res = '0;
        e_f = '0;
        e_tgt = '0;
        repeat (20) @(posedge ref_clk_i);
        #1;
        arst_n_i = 1;
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(negedge ref_clk_i) begin
        if (notes.size() > 0) begin
            nt = notes.pop_front();
            `CHK({result_o, result_wr_o},
                nt[69:37])
            `CHK(flags_o,
                nt[36:33])
            `CHK({branch_taken_o, branch_target_o},
                nt[32:0])
        end
    end

    // Hang guard
    initial begin
        #2000000;
        bad_count++;
        results();
    end

    initial begin
        sfb_op_req_s r;
        sfb_branch_req_s b;
        logic [31:0] y;
        do_reset();
        // Every shift kind at the boundary lengths, flagged
        for (int k = 0; k < 3; k++) begin
            foreach (amts[i]) begin
                r = mk(sfb_op_e'(8'h01 << k));
                r.amount = amts[i];
                r.set_flags = 1'b1;
                cyc(r, 1'b1, 1'b0, b, 5'h00);
            end
        end
        // Every condition against every flag pattern
        for (int k = 0; k < 256; k++) begin
            b = {sfb_cond_e'(k[3:0]), rnd()};
            cyc(r, 1'b0, 1'b0, b, {1'b1, k[7:4]});
            cyc(r, 1'b0, 1'b1, b, 5'h00);
        end
        // Random back-to-back mix, with a reset in mid-run
        for (int p = 0; p < 2; p++) begin
            if (p == 1) do_reset();
            repeat (1500) begin
                y = rnd();
                r = mk(sfb_op_e'(8'h01 << y[2:0]));
                b = {sfb_cond_e'(y[6:3]), rnd()};
                cyc(r, y[7] | y[8], y[9], b, y[14:10]);
            end
        end
        @(negedge ref_clk_i);
        #1;
        results();
    end
endmodule

`default_nettype wire
